// File: hw/i2mt_baud.sv
// i2mt_baud: baud rate rollover counter
// assumes run is held while a bus phase is timed; dropping run clears the count
`timescale 1ns/1ps
`default_nettype none
module i2mt_baud
  import i2mt_pkg::*;
#(
  parameter int W = i2mt_pkg::BAUD_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic [W-1:0] period,
  // rollover pulse
  output logic tick
);
  logic [W-1:0] count;
  wire at_end = (count >= period);
  assign tick = run && at_end;
  always_ff @(posedge clk) begin
    if (!nrst || !run || at_end) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hw/i2mt_bus_if.sv
// i2mt_bus_if: register-file to protocol engine signals
// assumes one clock domain; the top drives ctl and the engine drives eng
`timescale 1ns/1ps
`default_nettype none
interface i2mt_bus_if;
  logic load;
  logic [7:0] data;
  logic start_req;
  logic stop_req;
  logic restart_req;
  logic [7:0] baud;
  logic busy;
  logic full;
  logic done;
  logic ack_stat;
  logic ack_valid;
  logic cond_clear;
  modport ctl (output load, data, start_req, stop_req, restart_req, baud,
    input busy, full, done, ack_stat, ack_valid, cond_clear);
  modport eng (input load, data, start_req, stop_req, restart_req, baud,
    output busy, full, done, ack_stat, ack_valid, cond_clear);
endinterface
`default_nettype wire

// File: hw/i2mt_pkg.sv
// i2mt_pkg: constants shared by the i2c master transmit block
// assumes a 32-bit axi4-lite register bus and a 20 MHz system clock
package i2mt_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_BUF = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_BAUD = 8'h0C;
  localparam logic [7:0] OFF_IRQ = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  // control register 2 fields
  localparam int CTRL2_START = 0;
  localparam int CTRL2_RESTART = 1;
  localparam int CTRL2_STOP = 2;
  localparam int CTRL2_ACK_STATUS_BIT = 6;
  // status register fields
  localparam int STAT_FULL = 0;
  localparam int STAT_WRITE_COLLISION_FLAG = 7;
  // interrupt status fields
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int IRQ_NACK = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [7:0] BAUD_RST = 8'h09;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // baud rollover width
  localparam int BAUD_W = 8;
endpackage

// File: hw/i2mt_top.sv
// i2mt_top: i2c master transmit path with axi4-lite registers
// assumes open-drain scl/sda with external pull-ups, 20 MHz clk
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module i2mt_top
  import i2mt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // i2c pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // interrupt
  output logic irq
);
  i2mt_bus_if bus ();

  // write channel: hold each side until both are present
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire aw_go = s_axi_awvalid && s_axi_awready;
  wire w_go = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_go;
  wire have_w = w_held || w_go;
  wire wr_fire = have_aw && have_w && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_lane0 = wr_strb[0];
  wire wr_buf = wr_fire && wr_lane0 && (wr_addr == OFF_BUF);
  wire wr_ctrl2 = wr_fire && wr_lane0 && (wr_addr == OFF_CTRL2);
  wire wr_stat = wr_fire && wr_lane0 && (wr_addr == OFF_STAT);
  wire wr_baud = wr_fire && wr_lane0 && (wr_addr == OFF_BAUD);
  wire wr_mask = wr_fire && wr_lane0 && (wr_addr == OFF_MASK);
  wire wr_known = (wr_addr == OFF_BUF) || (wr_addr == OFF_CTRL2) ||
    (wr_addr == OFF_STAT) || (wr_addr == OFF_BAUD) ||
    (wr_addr == OFF_IRQ) || (wr_addr == OFF_MASK);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_go && !wr_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (w_go && !wr_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software-visible registers
  logic [7:0] tx_buffer_reg;
  logic [7:0] baud_reg;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_stat;
  logic write_collision_flag;
  logic start_cond_request;
  logic stop_cond_request;
  logic restart_cond_request;

  // a write during an active byte is dropped
  wire load_ok = wr_buf && !bus.busy;
  wire collide = wr_buf && bus.busy;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_buffer_reg <= 8'h00;
      baud_reg <= BAUD_RST;
      irq_mask <= MASK_RST;
      write_collision_flag <= 1'b0;
      start_cond_request <= 1'b0;
      stop_cond_request <= 1'b0;
      restart_cond_request <= 1'b0;
    end else begin
      if (load_ok) begin
        tx_buffer_reg <= wr_data[7:0];
      end
      if (wr_baud) begin
        baud_reg <= wr_data[7:0];
      end
      if (wr_mask) begin
        irq_mask <= wr_data[IRQ_W-1:0];
      end
      // only software clears it; a new collision beats the clear
      if (collide) begin
        write_collision_flag <= 1'b1;
      end else if (wr_stat && !wr_data[STAT_WRITE_COLLISION_FLAG]) begin
        write_collision_flag <= 1'b0;
      end
      // request bits self-clear when the condition completes
      if (wr_ctrl2 && !bus.busy) begin
        start_cond_request <= wr_data[CTRL2_START];
        restart_cond_request <= wr_data[CTRL2_RESTART];
        stop_cond_request <= wr_data[CTRL2_STOP];
      end else if (bus.cond_clear) begin
        start_cond_request <= 1'b0;
        restart_cond_request <= 1'b0;
        stop_cond_request <= 1'b0;
      end
    end
  end

  assign bus.load = load_ok;
  assign bus.data = wr_data[7:0];
  assign bus.start_req = start_cond_request;
  assign bus.stop_req = stop_cond_request;
  assign bus.restart_req = restart_cond_request;
  assign bus.baud = baud_reg;

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire [7:0] ctrl2_val = {1'b0, bus.ack_stat, 3'b000, stop_cond_request,
    restart_cond_request, start_cond_request};
  wire [7:0] stat_val = {write_collision_flag, 6'b00_0000, bus.full};
  logic [31:0] rd_val;
  logic rd_known;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      OFF_BUF: rd_val[7:0] = tx_buffer_reg;
      OFF_CTRL2: rd_val[7:0] = ctrl2_val;
      OFF_STAT: rd_val[7:0] = stat_val;
      OFF_BAUD: rd_val[7:0] = baud_reg;
      OFF_IRQ: rd_val[IRQ_W-1:0] = irq_stat;
      OFF_MASK: rd_val[IRQ_W-1:0] = irq_mask;
      default: rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sticky events; reading the interrupt status word clears it, new events win
  wire rd_irq = rd_go && (s_axi_araddr == OFF_IRQ);
  wire [IRQ_W-1:0] events;
  assign events[IRQ_DONE] = bus.done;
  assign events[IRQ_WRITE_COLLISION_FLAG] = collide;
  // the stored ack bit updates on this same edge, so look at the pin
  assign events[IRQ_NACK] = bus.ack_valid && sda_in;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (rd_irq ? '0 : irq_stat) | events;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  i2mt_engine u_engine (
    .clk(clk),
    .nrst(nrst),
    .bus(bus.eng),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
  );
endmodule

// protocol engine: start, byte transmit, ack, stop and restart
module i2mt_engine
  import i2mt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register side
  i2mt_bus_if.eng bus,
  // i2c pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ST_A, ST_ST_B, ST_BIT_LO, ST_BIT_HI, ST_ACK_LO, ST_ACK_HI,
    ST_HALT, ST_SP_A, ST_SP_B, ST_SP_C, ST_RS_A, ST_RS_B
  } i2mt_state_t;
  i2mt_state_t state;
  i2mt_state_t next_state;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt;
  logic scl_low;
  logic sda_low;
  logic ack_stat;
  logic buffer_full_flag;
  logic sda_pend;
  logic tick;

  wire run = (state != ST_IDLE) && (state != ST_HALT);
  i2mt_baud u_baud (
    .clk(clk),
    .nrst(nrst),
    .run(run),
    .period(bus.baud),
    .tick(tick)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (bus.start_req) next_state = ST_ST_A;
      end
      ST_HALT: begin
        if (bus.load) begin
          next_state = ST_BIT_LO;
        end else if (bus.stop_req) begin
          next_state = ST_SP_A;
        end else if (bus.restart_req) begin
          next_state = ST_RS_A;
        end
      end
      ST_ST_A: if (tick) next_state = ST_ST_B;
      ST_ST_B: if (tick) next_state = ST_HALT;
      ST_BIT_LO: if (tick) next_state = ST_BIT_HI;
      ST_BIT_HI: begin
        if (tick) next_state = (bit_cnt == 3'd7) ? ST_ACK_LO : ST_BIT_LO;
      end
      ST_ACK_LO: if (tick) next_state = ST_ACK_HI;
      ST_ACK_HI: if (tick) next_state = ST_HALT;
      ST_SP_A: if (tick) next_state = ST_SP_B;
      ST_SP_B: if (tick) next_state = ST_SP_C;
      ST_SP_C: if (tick) next_state = ST_IDLE;
      ST_RS_A: if (tick) next_state = ST_RS_B;
      ST_RS_B: if (tick) next_state = ST_ST_A;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt <= 3'd0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      ack_stat <= 1'b0;
      buffer_full_flag <= 1'b0;
      sda_pend <= 1'b0;
    end else begin
      state <= next_state;
      case (state)
        // start: sda falls with scl high, then scl low after hold
        ST_IDLE: if (bus.start_req) sda_low <= 1'b1;
        ST_ST_A: if (tick) scl_low <= 1'b1;
        // load starts the byte at once, msb first
        ST_HALT: if (bus.load) begin
          shift_reg <= {bus.data[6:0], 1'b0};
          sda_low <= !bus.data[7];
          bit_cnt <= 3'd0;
          buffer_full_flag <= 1'b1;
        end else if (bus.stop_req) begin
          sda_low <= 1'b1;
        end else if (bus.restart_req) begin
          sda_low <= 1'b0;
        end
        // data set while scl low, released high after one period
        ST_BIT_LO: if (tick) scl_low <= 1'b0;
        ST_BIT_HI: if (tick) begin
          scl_low <= 1'b1;
          bit_cnt <= bit_cnt + 3'd1;
          sda_pend <= 1'b1;
        end
        ST_ACK_LO: if (tick) scl_low <= 1'b0;
        // sample at the ninth falling edge; 1 means no ack
        ST_ACK_HI: if (tick) begin
          scl_low <= 1'b1;
          ack_stat <= sda_in;
        end
        ST_SP_A: if (tick) scl_low <= 1'b0;
        ST_SP_B: if (tick) sda_low <= 1'b0;
        ST_RS_A: if (tick) scl_low <= 1'b0;
        // repeated start: sda falls while scl is still released
        ST_RS_B: if (tick) sda_low <= 1'b1;
        default: ;
      endcase
      // sda moves one clock after scl falls, so it keeps a hold time
      if (sda_pend) begin
        sda_pend <= 1'b0;
        if (bit_cnt == 3'd0) begin
          // eighth falling edge frees sda for the slave
          sda_low <= 1'b0;
          buffer_full_flag <= 1'b0;
        end else begin
          sda_low <= !shift_reg[7];
          shift_reg <= {shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // scl high phase lasts one rollover, counted from release
  // halted with scl low after the ninth clock
  wire byte_done = (state == ST_ACK_HI) && tick;
  wire start_done = (state == ST_ST_B) && tick;
  wire stop_done = (state == ST_SP_C) && tick;
  assign bus.done = byte_done || start_done || stop_done;
  assign bus.ack_valid = byte_done;
  assign bus.ack_stat = ack_stat;
  assign bus.full = buffer_full_flag;
  assign bus.busy = (state != ST_HALT) && (state != ST_IDLE);
  assign bus.cond_clear = start_done || stop_done;

  // open drain: only pull low, never drive high
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low;
  assign sda_oe = sda_low;
endmodule
`default_nettype wire

// File: verif/i2mt_slave.sv
// i2mt_slave: behavioural i2c slave that captures bytes and acknowledges
// assumes scl and sda are resolved wire levels with pull-ups
`timescale 1ns/1ps
`default_nettype none
module i2mt_slave (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  // control and observation
  input wire logic ack_en,
  output logic sda_oe,
  output logic [7:0] rx_byte,
  output logic got_stop,
  output logic [3:0] starts
);
  logic [7:0] shreg;
  logic [3:0] cnt;
  initial begin
    sda_oe = 1'b0;
    rx_byte = 8'h0;
    got_stop = 1'b0;
    starts = 4'h0;
    cnt = 4'h0;
  end
  // start and stop are sda edges while scl is high
  always @(negedge sda) begin
    if (scl) begin
      cnt = 4'h0;
      got_stop = 1'b0;
      starts = starts + 4'h1;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      got_stop = 1'b1;
    end
  end
  always @(posedge scl) begin
    if (cnt < 4'h8) begin
      shreg = {shreg[6:0], sda};
    end
    cnt = cnt + 4'h1;
  end
  // ack held from the eighth fall to the ninth fall only
  always @(negedge scl) begin
    if (cnt == 4'h8) begin
      rx_byte = shreg;
      sda_oe = ack_en;
    end else if (cnt == 4'h9) begin
      sda_oe = 1'b0;
      cnt = 4'h0;
    end
  end
endmodule
`default_nettype wire

// File: verif/i2mt_top_sva.sv
// i2mt_top_sva: port-level checks for the i2c master transmit block
// assumes the baud period keeps its reset value of 9, ten clocks a phase
`timescale 1ns/1ps
`default_nettype none
module i2mt_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // i2c pin drivers
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_scl_low_len: assert property ($rose(scl_oe) |->
    ##1 scl_oe [*8] ##1 scl_oe)
    else $error("scl low phase shorter than ten clocks");
  chk_scl_high_len: assert property ($fell(scl_oe) |->
    ##1 !scl_oe [*8] ##1 !scl_oe)
    else $error("scl high phase shorter than ten clocks");
  // sda must not change in the same clock as either scl edge
  chk_sda_setup: assert property ($fell(scl_oe) |-> $stable(sda_oe))
    else $error("sda changed as scl was released");
  chk_sda_hold: assert property ($rose(scl_oe) |-> $stable(sda_oe))
    else $error("sda changed as scl was pulled low");
  chk_start_hold: assert property ($rose(sda_oe) && !scl_oe |->
    !scl_oe [*8] ##1 !scl_oe)
    else $error("scl pulled low too soon after start");
  chk_pins_low_only: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read response late");
  chk_write_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule

bind i2mt_top i2mt_top_sva sva_u (.clk, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .scl_out, .scl_oe,
  .sda_out, .sda_oe);
`default_nettype wire

// File: verif/tb.sv
// tb: self-checking bench for the i2c master transmit block
// assumes an axi4-lite master here and a pulled-up open-drain bus
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2mt_pkg::*;
  typedef struct packed {logic [7:0] data; logic ack;} i2mt_row_t;
  logic clk, nrst, ack_en, got_stop;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb, starts;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq;
  logic scl_out, scl_oe, sda_out, sda_oe, slv_oe;
  wire logic scl_w;
  wire logic sda_w;
  int fail_count, samples_checked;
  i2mt_row_t rows [3];
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || slv_oe);

  i2mt_top dut_u (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in(scl_w), .scl_out,
    .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe, .irq);
  i2mt_slave slv_u (.scl(scl_w), .sda(sda_w), .ack_en, .sda_oe(slv_oe),
    .rx_byte, .got_stop, .starts);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic timeout(input int n);
    if (n >= 1000) begin
      check(32'h0, 32'h1);
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready && !aw_done) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_done) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done) && n < 1000);
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_bvalid && n < 1000);
    s_axi_bready <= 1'b0;
    timeout(n);
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_arready && n < 1000);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_rvalid && n < 1000);
    s_axi_rready <= 1'b0;
    timeout(n);
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] rr;
    rd(a, d, rr);
    check(d, exp);
    check({30'h0, rr}, {30'h0, RESP_OKAY});
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    timeout(n);
  endtask

  initial begin
    nrst = 1'b0;
    ack_en = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    fail_count = 0;
    samples_checked = 0;
    rows = '{'{8'hA4, 1'b1}, '{8'h5B, 1'b1}, '{8'hC3, 1'b0}};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdc(OFF_BAUD, 32'h9);
    rdc(OFF_MASK, 32'h0);
    rdc(OFF_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    rd(8'h18, v, r);
    check(v, 32'h0);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h18, 32'hff, RESP_SLVERR);
    $display("test reset done");
    // mask still clear, so completion is polled in the request bit
    wr(OFF_CTRL2, 32'h1, RESP_OKAY);
    for (int i = 0; i < 20; i++) begin
      rd(OFF_CTRL2, v, r);
      if (v[CTRL2_START] == 1'b0) break;
    end
    check({31'h0, v[CTRL2_START]}, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h7, RESP_OKAY);
    check({31'h0, irq}, 32'h1);
    rdc(OFF_IRQ, 32'h1);
    rdc(OFF_IRQ, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test start done");
    for (int i = 0; i < 3; i++) begin
      ack_en <= rows[i].ack;
      wr(OFF_BUF, {24'h0, rows[i].data}, RESP_OKAY);
      rdc(OFF_STAT, 32'h1);
      wait_irq();
      rdc(OFF_IRQ, rows[i].ack ? 32'h1 : 32'h5);
      rdc(OFF_CTRL2, {25'h0, !rows[i].ack, 6'h0});
      rdc(OFF_STAT, 32'h0);
      check({24'h0, rx_byte}, {24'h0, rows[i].data});
      check({31'h0, scl_w}, 32'h0);
    end
    $display("test bytes done");
    ack_en <= 1'b1;
    wr(OFF_CTRL2, 32'h2, RESP_OKAY);
    wait_irq();
    rdc(OFF_IRQ, 32'h1);
    check({28'h0, starts}, 32'h2);
    $display("test restart done");
    // second write lands while the first byte is still shifting
    wr(OFF_BUF, 32'h3C, RESP_OKAY);
    wr(OFF_BUF, 32'h99, RESP_OKAY);
    rdc(OFF_BUF, 32'h3C);
    rdc(OFF_STAT, 32'h81);
    rdc(OFF_IRQ, 32'h2);
    wait_irq();
    rdc(OFF_IRQ, 32'h1);
    check({24'h0, rx_byte}, 32'h3C);
    rdc(OFF_STAT, 32'h80);
    wr(OFF_STAT, 32'h0, RESP_OKAY);
    rdc(OFF_STAT, 32'h0);
    $display("test collision done");
    check({31'h0, got_stop}, 32'h0);
    wr(OFF_CTRL2, 32'h4, RESP_OKAY);
    wait_irq();
    rdc(OFF_IRQ, 32'h1);
    check({31'h0, got_stop}, 32'h1);
    check({30'h0, scl_w, sda_w}, 32'h3);
    $display("test stop done");
    finish_test();
  end
endmodule
`default_nettype wire
